// file: mdrm_cfg.svh
// constants for the drive register mapper: register numbers, codes, counts
// assumes inclusion by bare name from the design modules; the package does not include it
`ifndef MDRM_CFG_SVH
`define MDRM_CFG_SVH
`define MDRM_PTR_REG      16'h270E
`define MDRM_DATA_REG     16'h270F
`define MDRM_DIRECT_OFS   16'h0001
`define MDRM_FC_READ_MULT 8'h03
`define MDRM_FC_WRITE_ONE 8'h06
`define MDRM_FC_WRITE_MUL 8'h10
`define MDRM_UNIT_A       8'h01
`define MDRM_UNIT_B       8'h02
`define MDRM_UNIT_C       8'h03
`define MDRM_EX_NONE      8'h00
`define MDRM_EX_FUNC      8'h01
`define MDRM_EX_ADDR      8'h02
`define MDRM_EX_VALUE     8'h03
`define MDRM_EX_REFUSED   8'h07
`define MDRM_EX_CHANNEL   8'h0A
`define MDRM_EX_NO_ANSWER 8'h0B
`define MDRM_PTR_RESET    16'h0000
`define MDRM_NUM_CHAN     3
`define MDRM_NUM_POINTS   8
`endif

// file: mdrm_drive_model.sv
// behavioural drive side: answers each drive request after a set delay
// assumes one request at a time; bench sets delay (1 or more) and status
`timescale 1ns/100ps
module mdrm_drive_model (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  // drive transaction
  input  wire logic                       drv_req,
  input  wire logic [1:0]                 drv_chan,
  input  wire logic [15:0]                drv_index,
  output logic                            drv_done,
  output mdrm_pkg::mdrm_drv_status_t      drv_status,
  output logic [15:0]                     drv_rdata,
  // bench controls
  input  wire logic [7:0]                 delay_cycles,
  input  wire mdrm_pkg::mdrm_drv_status_t answer_status
);
  logic [7:0]  cnt_reg;
  logic [15:0] val_reg;
  logic        done_reg;
  logic        flip_reg;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt_reg  <= 8'h00;
      done_reg <= 1'b0;
      flip_reg <= 1'b0;
    end else begin
      flip_reg <= ~flip_reg;
      done_reg <= (cnt_reg == 8'h01);
      if (drv_req) begin
        cnt_reg <= delay_cycles;
        val_reg <= drv_index ^ 16'h5A5A ^ {14'h0000, drv_chan};
      end else if (cnt_reg != 8'h00) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end

  // outside the answer cycle the data lines toggle and the status shows its inverse, so stale data cannot pass
  assign drv_done   = done_reg;
  assign drv_rdata  = done_reg ? val_reg : ~val_reg ^ {16{flip_reg}};
  assign drv_status = done_reg ? answer_status :
                      mdrm_pkg::mdrm_drv_status_t'(~answer_status);
endmodule // mdrm_drive_model

// file: mdrm_mapper.sv
// request resolver: one holding register per request to a drive channel
// assumes a front end splits multi-register requests into single items
`timescale 1ns/100ps
`include "mdrm_cfg.svh"
module mdrm_mapper #(
  parameter int NUM_CHAN   = `MDRM_NUM_CHAN,
  parameter int NUM_POINTS = `MDRM_NUM_POINTS
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // network request, one register per item
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [7:0]  req_unit,
  input  wire logic [7:0]  req_func,
  input  wire logic [15:0] req_reg,
  input  wire logic [15:0] req_wdata,
  // network answer
  output logic             rsp_valid,
  output logic [7:0]       rsp_exception,
  output logic [15:0]      rsp_rdata,
  // drive transaction
  output logic             drv_req,
  output logic [1:0]       drv_chan,
  output logic             drv_write,
  output logic [15:0]      drv_index,
  output logic [15:0]      drv_wdata,
  input  wire logic        drv_done,
  input  wire mdrm_pkg::mdrm_drv_status_t drv_status,
  input  wire logic [15:0] drv_rdata,
  // point configuration and mirroring
  input  wire logic        cfg_we,
  input  wire logic [1:0]  cfg_chan,
  input  wire logic [$clog2(NUM_POINTS)-1:0] cfg_slot,
  input  wire logic        cfg_valid,
  input  wire logic [15:0] cfg_net_index,
  input  wire logic [15:0] cfg_drv_index,
  input  wire logic [15:0] cfg_value,
  output logic [NUM_CHAN-1:0] cfg_reject,
  input  wire logic        mir_we,
  input  wire logic [1:0]  mir_chan,
  input  wire logic [$clog2(NUM_POINTS)-1:0] mir_slot,
  input  wire logic [15:0] mir_value
);
  localparam int SW = $clog2(NUM_POINTS);

  typedef struct packed {
    mdrm_pkg::mdrm_state_t         fsm;
    logic [1:0]                    chan;
    logic                          write;
    logic [15:0]                   reg_num;
    logic [15:0]                   wdata;
    logic [15:0]                   index;
    logic [7:0]                    exc;
    logic [15:0]                   rdata;
    logic                          drv_req;
    logic [NUM_CHAN-1:0][15:0]     ptr;
  } mdrm_state_t;

  mdrm_state_t st_reg;
  mdrm_state_t st_next;

  logic [NUM_CHAN-1:0]       pt_hit;
  logic [NUM_CHAN-1:0][15:0] pt_drv;
  logic [NUM_CHAN-1:0][15:0] pt_val;

  genvar gc;
  generate
    for (gc = 0; gc < NUM_CHAN; gc++) begin : g_chan
      mdrm_point_table #(
        .NUM_POINTS (NUM_POINTS)
      ) u_points (
        .ref_clk       (ref_clk),
        .srst          (srst),
        .cfg_we        (cfg_we && cfg_chan == 2'(gc)),
        .cfg_slot      (cfg_slot),
        .cfg_valid     (cfg_valid),
        .cfg_net_index (cfg_net_index),
        .cfg_drv_index (cfg_drv_index),
        .cfg_value     (cfg_value),
        .cfg_reject    (cfg_reject[gc]),
        .mir_we        (mir_we && mir_chan == 2'(gc)),
        .mir_slot      (mir_slot),
        .mir_value     (mir_value),
        .lk_net_index  (st_reg.reg_num),
        .lk_hit        (pt_hit[gc]),
        .lk_drv_index  (pt_drv[gc]),
        .lk_value      (pt_val[gc])
      );
    end
  endgenerate

  logic func_ok;
  logic unit_ok;
  assign func_ok = (req_func == `MDRM_FC_READ_MULT) ||
                   (req_func == `MDRM_FC_WRITE_ONE) ||
                   (req_func == `MDRM_FC_WRITE_MUL);
  assign unit_ok = (req_unit == `MDRM_UNIT_A) ||
                   (req_unit == `MDRM_UNIT_B) ||
                   (req_unit == `MDRM_UNIT_C);

  always_comb begin
    st_next = st_reg;
    st_next.drv_req = 1'b0;
    case (st_reg.fsm)
      mdrm_pkg::MDRM_IDLE: begin
        if (req_valid) begin
          st_next.write   = (req_func != `MDRM_FC_READ_MULT);
          st_next.reg_num = req_reg;
          st_next.wdata   = req_wdata;
          st_next.rdata   = 16'h0000;
          st_next.exc     = `MDRM_EX_NONE;
          st_next.chan    = 2'(req_unit - `MDRM_UNIT_A);
          if (!func_ok) begin
            st_next.exc = `MDRM_EX_FUNC;
            st_next.fsm = mdrm_pkg::MDRM_ANSWER;
          end else if (!unit_ok) begin
            st_next.exc = `MDRM_EX_CHANNEL;
            st_next.fsm = mdrm_pkg::MDRM_ANSWER;
          end else begin
            st_next.fsm = mdrm_pkg::MDRM_LOOKUP;
          end
        end
      end
      mdrm_pkg::MDRM_LOOKUP: begin
        // items resolve on their own, except through the per-channel pointer written at 270E
        if (st_reg.reg_num == `MDRM_PTR_REG) begin
          if (st_reg.write) begin
            st_next.ptr[st_reg.chan] = st_reg.wdata;
          end
          // a write answers with the value just stored, as point writes and drive writes with status OK do
          st_next.rdata = st_reg.write ? st_reg.wdata
                                       : st_reg.ptr[st_reg.chan];
          st_next.fsm = mdrm_pkg::MDRM_ANSWER;
        end else if (st_reg.reg_num == `MDRM_DATA_REG) begin
          st_next.index = st_reg.ptr[st_reg.chan];
          st_next.fsm = mdrm_pkg::MDRM_DRIVE;
        end else if (pt_hit[st_reg.chan]) begin
          st_next.index = pt_drv[st_reg.chan];
          // writes are answered here and never go to the drive; range errors are not seen here
          st_next.rdata = st_reg.write ? st_reg.wdata
                                       : pt_val[st_reg.chan];
          st_next.fsm = mdrm_pkg::MDRM_ANSWER;
        end else if (st_reg.reg_num == 16'h0000) begin
          st_next.exc = `MDRM_EX_ADDR;
          st_next.fsm = mdrm_pkg::MDRM_ANSWER;
        end else begin
          st_next.index = st_reg.reg_num - `MDRM_DIRECT_OFS;
          st_next.fsm = mdrm_pkg::MDRM_DRIVE;
        end
      end
      mdrm_pkg::MDRM_DRIVE: begin
        st_next.drv_req = 1'b1;
        st_next.fsm = mdrm_pkg::MDRM_WAIT;
      end
      mdrm_pkg::MDRM_WAIT: begin
        if (drv_done) begin
          st_next.rdata = st_reg.write ? st_reg.wdata : drv_rdata;
          case (drv_status)
            mdrm_pkg::MDRM_DRV_OK:        st_next.exc = `MDRM_EX_NONE;
            mdrm_pkg::MDRM_DRV_NO_REG:    st_next.exc = `MDRM_EX_ADDR;
            mdrm_pkg::MDRM_DRV_BAD_VALUE: st_next.exc = `MDRM_EX_VALUE;
            mdrm_pkg::MDRM_DRV_READ_ONLY,
            mdrm_pkg::MDRM_DRV_LOCKED:    st_next.exc = `MDRM_EX_REFUSED;
            default:                      st_next.exc = `MDRM_EX_NO_ANSWER;
          endcase
          if (drv_status != mdrm_pkg::MDRM_DRV_OK) begin
            st_next.rdata = 16'h0000;
          end
          st_next.fsm = mdrm_pkg::MDRM_ANSWER;
        end
      end
      mdrm_pkg::MDRM_ANSWER: begin
        st_next.fsm = mdrm_pkg::MDRM_IDLE;
      end
      default: begin
        st_next.fsm = mdrm_pkg::MDRM_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
      st_reg.fsm <= mdrm_pkg::MDRM_IDLE;
      st_reg.ptr <= {NUM_CHAN{`MDRM_PTR_RESET}};
    end else begin
      st_reg <= st_next;
    end
  end

  assign req_ready     = (st_reg.fsm == mdrm_pkg::MDRM_IDLE);
  assign rsp_valid     = (st_reg.fsm == mdrm_pkg::MDRM_ANSWER);
  assign rsp_exception = st_reg.exc;
  assign rsp_rdata     = st_reg.rdata;
  assign drv_req       = st_reg.drv_req;
  assign drv_chan      = st_reg.chan;
  assign drv_write     = st_reg.write;
  assign drv_index     = st_reg.index;
  assign drv_wdata     = st_reg.wdata;

  AST_BAD_FUNC: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_ready && !func_ok
    |-> ##1 rsp_valid && rsp_exception == 8'h01)
    else $error("bad function not answered with 01");
  AST_BAD_UNIT: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_ready && func_ok && !unit_ok
    |-> ##1 rsp_valid && rsp_exception == 8'h0A)
    else $error("bad unit not answered with 0A");
  AST_DIRECT_MAP: assert property (@(posedge ref_clk) disable iff (srst)
    req_valid && req_ready && func_ok && unit_ok
    ##1 (st_reg.reg_num != 16'h270E && st_reg.reg_num != 16'h270F &&
         st_reg.reg_num != 16'h0000 && !pt_hit[st_reg.chan])
    |-> ##2 drv_req && drv_index == $past(st_reg.reg_num, 2) - 16'h0001)
    else $error("direct map index not one below");
  AST_POINT_LOCAL: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == mdrm_pkg::MDRM_LOOKUP && pt_hit[st_reg.chan] &&
    st_reg.reg_num != 16'h270F && st_reg.reg_num != 16'h270E
    |=> rsp_valid && !drv_req)
    else $error("point request went to drive");
  AST_WINDOW_PTR: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == mdrm_pkg::MDRM_LOOKUP && st_reg.reg_num == 16'h270F
    |-> ##2 drv_req && drv_index == $past(st_reg.ptr[st_reg.chan], 2))
    else $error("data window not redirected through pointer");
  AST_PTR_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
    !(st_reg.fsm == mdrm_pkg::MDRM_LOOKUP && st_reg.write &&
      st_reg.reg_num == 16'h270E) |=> $stable(st_reg.ptr))
    else $error("pointer changed without a write");
  AST_DRV_NO_REG: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == mdrm_pkg::MDRM_WAIT && drv_done &&
    drv_status == mdrm_pkg::MDRM_DRV_NO_REG
    |=> rsp_valid && rsp_exception == 8'h02)
    else $error("missing register not answered with 02");
  AST_DRV_REFUSE: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == mdrm_pkg::MDRM_WAIT && drv_done &&
    (drv_status == mdrm_pkg::MDRM_DRV_READ_ONLY ||
     drv_status == mdrm_pkg::MDRM_DRV_LOCKED)
    |=> rsp_valid && rsp_exception == 8'h07)
    else $error("refused write not answered with 07");
  AST_DRV_VALUE: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == mdrm_pkg::MDRM_WAIT && drv_done &&
    drv_status == mdrm_pkg::MDRM_DRV_BAD_VALUE
    |=> rsp_exception == 8'h03)
    else $error("bad value not answered with 03");
  AST_DRV_OFFLINE: assert property (@(posedge ref_clk) disable iff (srst)
    st_reg.fsm == mdrm_pkg::MDRM_WAIT && drv_done &&
    drv_status == mdrm_pkg::MDRM_DRV_OFFLINE
    |=> rsp_exception == 8'h0B)
    else $error("offline drive not answered with 0B");

  COV_DIRECT: cover property (@(posedge ref_clk) drv_req && !drv_write);
  COV_WINDOW: cover property (@(posedge ref_clk)
    st_reg.fsm == mdrm_pkg::MDRM_LOOKUP && st_reg.reg_num == 16'h270F);
  COV_POINT: cover property (@(posedge ref_clk)
    st_reg.fsm == mdrm_pkg::MDRM_LOOKUP && pt_hit[st_reg.chan]);
  COV_EXC: cover property (@(posedge ref_clk)
    rsp_valid && rsp_exception == 8'h0A);
endmodule // mdrm_mapper

// file: mdrm_mapper_tb.sv
// self-checking bench for the drive register mapper
// assumes the drive model file and the design package are compiled first
`timescale 1ns/100ps
module mdrm_mapper_tb;
  logic        ref_clk = 1'b0;
  logic        srst, req_valid, req_ready, rsp_valid, drv_req, drv_write;
  logic        drv_done, cfg_we, cfg_valid, mir_we, m_wr;
  logic [7:0]  req_unit, req_func, rsp_exception, dly;
  logic [15:0] req_reg, req_wdata, rsp_rdata, drv_index, drv_wdata;
  logic [15:0] drv_rdata, cfg_net_index, cfg_drv_index, cfg_value;
  logic [15:0] mir_value, m_idx, m_wd;
  logic [1:0]  drv_chan, cfg_chan, mir_chan, m_chan;
  logic [2:0]  cfg_slot, mir_slot, cfg_reject;
  mdrm_pkg::mdrm_drv_status_t drv_status, st;
  int          fails = 0;
  int          checks_done = 0;
  int          n_drv = 0;
  int          cyc = 0;

  always #12.5 ref_clk = ~ref_clk;

  mdrm_mapper i_mdrm_mapper (
    .ref_clk(ref_clk), .srst(srst), .req_valid(req_valid),
    .req_ready(req_ready), .req_unit(req_unit), .req_func(req_func),
    .req_reg(req_reg), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_exception(rsp_exception), .rsp_rdata(rsp_rdata),
    .drv_req(drv_req), .drv_chan(drv_chan), .drv_write(drv_write),
    .drv_index(drv_index), .drv_wdata(drv_wdata), .drv_done(drv_done),
    .drv_status(drv_status), .drv_rdata(drv_rdata), .cfg_we(cfg_we),
    .cfg_chan(cfg_chan), .cfg_slot(cfg_slot), .cfg_valid(cfg_valid),
    .cfg_net_index(cfg_net_index), .cfg_drv_index(cfg_drv_index),
    .cfg_value(cfg_value), .cfg_reject(cfg_reject), .mir_we(mir_we),
    .mir_chan(mir_chan), .mir_slot(mir_slot), .mir_value(mir_value));

  mdrm_drive_model i_mdrm_drive_model (
    .ref_clk(ref_clk), .srst(srst), .drv_req(drv_req),
    .drv_chan(drv_chan), .drv_index(drv_index), .drv_done(drv_done),
    .drv_status(drv_status), .drv_rdata(drv_rdata),
    .delay_cycles(dly), .answer_status(st));

  // record what the mapper asked of the drive
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (drv_req === 1'b1) begin
      n_drv <= n_drv + 1;
      m_idx <= drv_index;
      m_chan <= drv_chan;
      m_wr <= drv_write;
      m_wd <= drv_wdata;
    end
    if (cyc == 20000) begin
      fails = fails + 1;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk16(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk8(input string n, input logic [7:0] e, g);
    chk16(n, {8'h00, e}, {8'h00, g});
  endtask

  function automatic logic [15:0] rdx(input logic [1:0] c, logic [15:0] i);
    return i ^ 16'h5A5A ^ {14'h0000, c};
  endfunction

  // one item: hold request until taken, then judge the answer
  task automatic xfer(input logic [7:0] u, f, input logic [15:0] r, w,
                      input logic [7:0] ex, input logic [15:0] rd,
                      input logic nd, input logic [15:0] idx);
    int n0;
    int k;
    n0 = n_drv;
    k = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_unit <= u;
    req_func <= f;
    req_reg <= r;
    req_wdata <= w;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && k < 50) begin
      k++;
      @(negedge ref_clk);
    end
    @(posedge ref_clk);
    req_valid <= 1'b0;
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (rsp_valid !== 1'b1 && k < 200);
    chk8("answer", 8'h01, {7'h00, rsp_valid});
    chk8("exception", ex, rsp_exception);
    chk16("read data", rd, rsp_rdata);
    chk8("drive requests", {7'h00, nd}, 8'(n_drv - n0));
    if (nd) begin
      chk16("drive index", idx, m_idx);
      chk8("drive channel", {6'h00, 2'(u - 8'h01)}, {6'h00, m_chan});
      chk8("drive write", {7'h00, f != 8'h03}, {7'h00, m_wr});
      chk16("drive write data", w, m_wd);
    end
  endtask

  task automatic cfg(input logic [1:0] c, input logic [2:0] s,
                     input logic v, input logic [15:0] n, d, val,
                     input logic [2:0] rj);
    logic [2:0] seen;
    @(posedge ref_clk);
    cfg_we <= 1'b1;
    cfg_chan <= c;
    cfg_slot <= s;
    cfg_valid <= v;
    cfg_net_index <= n;
    cfg_drv_index <= d;
    cfg_value <= val;
    @(posedge ref_clk);
    cfg_we <= 1'b0;
    @(negedge ref_clk);
    seen = cfg_reject;
    @(negedge ref_clk);
    seen = seen | cfg_reject;
    chk8("config reject", {5'h00, rj}, {5'h00, seen});
  endtask

  task automatic t_direct();
    for (int u = 1; u <= 3; u++) begin
      xfer(8'(u), 8'h03, 16'h000A, 16'h0000, 8'h00,
           rdx(2'(u - 1), 16'h0009), 1'b1, 16'h0009);
    end
    xfer(8'h02, 8'h06, 16'h0101, 16'h0BEE, 8'h00, 16'h0BEE, 1'b1, 16'h0100);
    xfer(8'h03, 8'h10, 16'hFFFF, 16'h1234, 8'h00, 16'h1234, 1'b1, 16'hFFFE);
    dly = 8'd20;
    xfer(8'h01, 8'h03, 16'h0001, 16'h0000, 8'h00, rdx(2'h0, 16'h0000),
         1'b1, 16'h0000);
    dly = 8'd1;
    $display("test direct done");
  endtask

  task automatic t_refuse();
    xfer(8'h01, 8'h04, 16'h000A, 16'h0000, 8'h01, 16'h0000, 1'b0, 16'h0000);
    xfer(8'h00, 8'h05, 16'h000A, 16'h0000, 8'h01, 16'h0000, 1'b0, 16'h0000);
    xfer(8'h00, 8'h03, 16'h000A, 16'h0000, 8'h0A, 16'h0000, 1'b0, 16'h0000);
    xfer(8'h04, 8'h06, 16'h000A, 16'h0001, 8'h0A, 16'h0000, 1'b0, 16'h0000);
    xfer(8'h01, 8'h03, 16'h0000, 16'h0000, 8'h02, 16'h0000, 1'b0, 16'h0000);
    $display("test refuse done");
  endtask

  task automatic t_status();
    mdrm_pkg::mdrm_drv_status_t sl[5] = '{mdrm_pkg::MDRM_DRV_NO_REG,
      mdrm_pkg::MDRM_DRV_BAD_VALUE, mdrm_pkg::MDRM_DRV_READ_ONLY,
      mdrm_pkg::MDRM_DRV_LOCKED, mdrm_pkg::MDRM_DRV_OFFLINE};
    logic [7:0] el[5] = '{8'h02, 8'h03, 8'h07, 8'h07, 8'h0B};
    for (int i = 0; i < 5; i++) begin
      st = sl[i];
      xfer(8'h01, 8'h06, 16'h0005, 16'h0011, el[i], 16'h0000,
           1'b1, 16'h0004);
    end
    st = mdrm_pkg::MDRM_DRV_OK;
    $display("test status done");
  endtask

  task automatic t_points();
    cfg(2'h0, 3'h0, 1'b1, 16'h0020, 16'h0100, 16'h1234, 3'h0);
    xfer(8'h01, 8'h03, 16'h0020, 16'h0000, 8'h00, 16'h1234, 1'b0, 16'h0000);
    xfer(8'h02, 8'h03, 16'h0020, 16'h0000, 8'h00, rdx(2'h1, 16'h001F),
         1'b1, 16'h001F);
    cfg(2'h0, 3'h1, 1'b1, 16'h270E, 16'h0200, 16'h5555, 3'h1);
    cfg(2'h2, 3'h2, 1'b1, 16'h270F, 16'h0200, 16'h5555, 3'h4);
    xfer(8'h01, 8'h03, 16'h270E, 16'h0000, 8'h00, 16'h0200, 1'b0, 16'h0000);
    @(posedge ref_clk);
    mir_we <= 1'b1;
    mir_chan <= 2'h0;
    mir_slot <= 3'h0;
    mir_value <= 16'h4321;
    @(posedge ref_clk);
    mir_we <= 1'b0;
    xfer(8'h01, 8'h03, 16'h0020, 16'h0000, 8'h00, 16'h4321, 1'b0, 16'h0000);
    cfg(2'h0, 3'h0, 1'b0, 16'h0020, 16'h0100, 16'h0000, 3'h0);
    xfer(8'h01, 8'h03, 16'h0020, 16'h0000, 8'h00, rdx(2'h0, 16'h001F),
         1'b1, 16'h001F);
    $display("test points done");
  endtask

  task automatic t_indirect();
    xfer(8'h03, 8'h03, 16'h270E, 16'h0000, 8'h00, 16'h0000, 1'b0, 16'h0000);
    xfer(8'h02, 8'h06, 16'h270E, 16'h0064, 8'h00, 16'h0064, 1'b0, 16'h0000);
    xfer(8'h02, 8'h03, 16'h270E, 16'h0000, 8'h00, 16'h0064, 1'b0, 16'h0000);
    xfer(8'h02, 8'h03, 16'h270F, 16'h0000, 8'h00, rdx(2'h1, 16'h0064),
         1'b1, 16'h0064);
    xfer(8'h01, 8'h10, 16'h270E, 16'h0200, 8'h00, 16'h0200, 1'b0, 16'h0000);
    xfer(8'h02, 8'h06, 16'h270F, 16'h0777, 8'h00, 16'h0777, 1'b1, 16'h0064);
    xfer(8'h01, 8'h03, 16'h270F, 16'h0000, 8'h00, rdx(2'h0, 16'h0200),
         1'b1, 16'h0200);
    xfer(8'h01, 8'h03, 16'h0201, 16'h0000, 8'h00, rdx(2'h0, 16'h0200),
         1'b1, 16'h0200);
    $display("test indirect done");
  endtask

  initial begin
    srst = 1'b1;
    {req_valid, cfg_we, cfg_valid, mir_we} = 4'h0;
    {req_unit, req_func, req_reg, req_wdata} = 48'h0;
    {cfg_chan, cfg_slot, mir_chan, mir_slot} = 10'h000;
    {cfg_net_index, cfg_drv_index, cfg_value, mir_value} = 64'h0;
    dly = 8'd1;
    st = mdrm_pkg::MDRM_DRV_OK;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    t_indirect();
    t_direct();
    t_refuse();
    t_status();
    t_points();
    stop_test();
  end
endmodule // mdrm_mapper_tb

// file: mdrm_pkg.sv
// types shared by the drive register mapper modules
// assumes mdrm_cfg.svh on the include path
package mdrm_pkg;
  typedef enum logic [2:0] {
    MDRM_IDLE,
    MDRM_LOOKUP,
    MDRM_DRIVE,
    MDRM_WAIT,
    MDRM_ANSWER
  } mdrm_state_t;

  // drive answer status
  typedef enum logic [2:0] {
    MDRM_DRV_OK,
    MDRM_DRV_NO_REG,
    MDRM_DRV_BAD_VALUE,
    MDRM_DRV_READ_ONLY,
    MDRM_DRV_LOCKED,
    MDRM_DRV_OFFLINE
  } mdrm_drv_status_t;
endpackage

// file: mdrm_point_table.sv
// point database of one drive channel: network index to drive index
// assumes a configuration agent writes entries; reserved numbers are refused
`timescale 1ns/100ps
`include "mdrm_cfg.svh"
module mdrm_point_table #(
  parameter int NUM_POINTS = `MDRM_NUM_POINTS
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // configuration write
  input  wire logic        cfg_we,
  input  wire logic [$clog2(NUM_POINTS)-1:0] cfg_slot,
  input  wire logic        cfg_valid,
  input  wire logic [15:0] cfg_net_index,
  input  wire logic [15:0] cfg_drv_index,
  input  wire logic [15:0] cfg_value,
  output logic             cfg_reject,
  // mirrored value update
  input  wire logic        mir_we,
  input  wire logic [$clog2(NUM_POINTS)-1:0] mir_slot,
  input  wire logic [15:0] mir_value,
  // lookup
  input  wire logic [15:0] lk_net_index,
  output logic             lk_hit,
  output logic [15:0]      lk_drv_index,
  output logic [15:0]      lk_value
);
  typedef struct packed {
    logic [NUM_POINTS-1:0]       used;
    logic [NUM_POINTS-1:0][15:0] net;
    logic [NUM_POINTS-1:0][15:0] drv;
    logic [NUM_POINTS-1:0][15:0] val;
    logic                        reject;
  } mdrm_pt_state_t;

  mdrm_pt_state_t st_reg;
  mdrm_pt_state_t st_next;
  logic reserved_num;

  assign reserved_num = (cfg_net_index == `MDRM_PTR_REG) ||
                        (cfg_net_index == `MDRM_DATA_REG);

  always_comb begin
    st_next = st_reg;
    st_next.reject = 1'b0;
    if (cfg_we) begin
      if (cfg_valid && reserved_num) begin
        st_next.reject = 1'b1;
      end else begin
        st_next.used[cfg_slot] = cfg_valid;
        st_next.net[cfg_slot]  = cfg_net_index;
        st_next.drv[cfg_slot]  = cfg_drv_index;
        st_next.val[cfg_slot]  = cfg_value;
      end
    end
    // mirror update loses to a same-cycle configuration of the slot
    if (mir_we && !(cfg_we && cfg_slot == mir_slot)) begin
      st_next.val[mir_slot] = mir_value;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cfg_reject = st_reg.reject;

  logic [NUM_POINTS-1:0] hit_vec;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_POINTS; gi++) begin : g_match
      assign hit_vec[gi] = st_reg.used[gi] &&
                           (st_reg.net[gi] == lk_net_index);
    end
  endgenerate

  always_comb begin
    lk_hit = 1'b0;
    lk_drv_index = 16'h0000;
    lk_value = 16'h0000;
    for (int i = NUM_POINTS - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        lk_hit = 1'b1;
        lk_drv_index = st_reg.drv[i];
        lk_value = st_reg.val[i];
      end
    end
  end

  AST_RESERVED_REFUSED: assert property (@(posedge ref_clk) disable iff (srst)
    cfg_we && cfg_valid && reserved_num |=> cfg_reject)
    else $error("reserved number accepted as point");
  AST_RESERVED_NEVER_HIT: assert property (@(posedge ref_clk) disable iff (srst)
    (lk_net_index == `MDRM_PTR_REG || lk_net_index == `MDRM_DATA_REG)
    |-> !lk_hit)
    else $error("reserved number found in point table");
endmodule // mdrm_point_table
